// ---- rtl/lcbf_config_decode.sv ----
/*
 * LED current and boost frequency configuration decode.
 * Takes host-written fields or strap levels and presents registered
 * sink current, trim, multiplier and boost frequency settings.
 * Assumes all inputs synchronous to clk; the host write port is a
 * one-cycle strobe per field; switch_start pulses when the boost starts.
 * Stored fields other than the current code show one edge after a write;
 * derived values and max_i_code two edges after; a user sampling both must allow for that skew.
 * The frequency lock is only left by reset; the strap level seen on
 * the edge that samples switch_start is the one kept.
 */
`timescale 1ns/1ns
`include "lcbf_regs.svh"
module lcbf_config_decode #(
    parameter logic [`LCBF_CODE_W-1:0] FSW_RESET = `LCBF_FSW_RESET,
    parameter logic [`LCBF_MULT_W-1:0] MULT_NONI2C = `LCBF_MULT_NONI2C
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic i2c_mode,
    input wire logic max_i_wr,
    input wire logic [`LCBF_CODE_W-1:0] max_i_wdata,
    input wire logic trim_wr,
    input wire logic [`LCBF_TRIM_W-1:0] trim_wdata,
    input wire logic fsw_wr,
    input wire logic [`LCBF_CODE_W-1:0] fsw_wdata,
    input wire logic ext_sel_wr,
    input wire logic ext_sel_wdata,
    input wire logic pwm_mode,
    input wire logic [`LCBF_DUTY_W-1:0] pwm_duty,
    input wire lcbf_pkg::lcbf_sda_t sda_strap,
    input wire logic switch_start,
    output logic [`LCBF_CODE_W-1:0] max_i_code,
    output logic [`LCBF_MA_W-1:0] full_scale_ma,
    output logic [`LCBF_TRIM_W-1:0] current_fine_trim,
    output logic [`LCBF_TRIM_PCT_W-1:0] trim_pct_x100,
    output logic [`LCBF_UA_W-1:0] sink_current_ua,
    output logic external_resistor_select,
    output logic [`LCBF_MULT_W-1:0] resistor_current_multiplier,
    output logic [`LCBF_DUTY_W-1:0] current_duty_scale,
    output logic [`LCBF_CODE_W-1:0] fsw_code,
    output logic [`LCBF_KHZ_W-1:0] fsw_khz,
    output logic fsw_locked,
    output logic fsw_reserved_err
);
    ////////////////////////////////////////////////////////////////////////
    // stored configuration and latch state
    logic [`LCBF_CODE_W-1:0] max_i_reg, max_i_next;
    logic [`LCBF_TRIM_W-1:0] trim_reg, trim_next;
    logic ext_reg, ext_next;
    logic [`LCBF_CODE_W-1:0] fsw_reg, fsw_next;
    logic rsv_reg, rsv_next;
    lcbf_pkg::lcbf_state_t state_reg, state_next;
    // output copies, a cycle behind the stored fields
    logic [`LCBF_CODE_W-1:0] max_i_out_reg;
    logic [`LCBF_MA_W-1:0] ma_reg;
    logic [`LCBF_TRIM_PCT_W-1:0] pct_reg;
    logic [`LCBF_UA_W-1:0] ua_reg;
    logic [`LCBF_MULT_W-1:0] mult_reg;
    logic [`LCBF_DUTY_W-1:0] duty_reg;
    logic [`LCBF_KHZ_W-1:0] khz_reg;

    // frequency from a code; used for the host code and the strap code
    // rounds to nearest like the frequency table; truncation loses a kHz
    function automatic logic [`LCBF_KHZ_W-1:0] code_to_khz(
        input logic [`LCBF_CODE_W-1:0] c
    );
        logic [`LCBF_KHZ_W-1:0] div;
        logic [`LCBF_KHZ_W-1:0] half;
        div = {{(`LCBF_KHZ_W-`LCBF_CODE_W){1'b0}}, c} + 14'h0001;
        half = div >> 1;
        code_to_khz = (`LCBF_BASE_KHZ + half) / div;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode of the active settings
    wire locked = (state_reg == lcbf_pkg::LCBF_ST_LOCKED);
    wire fsw_rsv_code = (fsw_wdata < `LCBF_FSW_MIN_CODE);

    // grounded strap falls back to the reset default, so a build with
    // another default moves the grounded frequency with it
    wire [`LCBF_CODE_W-1:0] strap_code =
        (sda_strap == lcbf_pkg::LCBF_SDA_HIGH) ? `LCBF_FSW_SDA_HIGH :
        (sda_strap == lcbf_pkg::LCBF_SDA_OPEN) ? `LCBF_FSW_SDA_OPEN :
        FSW_RESET;

    // coarse current and fine trim percentage
    wire [`LCBF_MA_W-1:0] coarse_ma =
        `LCBF_BASE_MA + {1'b0, max_i_reg};
    wire [`LCBF_TRIM_PCT_W-1:0] pct_calc = 10'(
        (32'(`LCBF_TRIM_TOP) * 32'(trim_reg)) / 32'(`LCBF_TRIM_STEPS));
    // trimmed current in microamps; 32 bits hold 43 mA at full trim
    wire [31:0] ua_coarse = 32'(coarse_ma) * `LCBF_UA_PER_MA;
    wire [31:0] ua_gain = `LCBF_PCT_SCALE + 32'(pct_calc);
    wire [31:0] ua_trim = (ua_coarse * ua_gain) / `LCBF_PCT_SCALE;

    // strap mode multiplier is fixed by the MULT_NONI2C parameter
    wire [`LCBF_MULT_W-1:0] table_mult;
    wire [`LCBF_MULT_W-1:0] mult_sel =
        i2c_mode ? table_mult : MULT_NONI2C;

    // duty only scales the current in external resistor mode
    wire use_duty = pwm_mode & ext_reg;
    wire [`LCBF_DUTY_W-1:0] duty_sel = use_duty ? pwm_duty : `LCBF_DUTY_FULL;
    wire [31:0] ua_scaled = (ua_trim * 32'(duty_sel)) / 32'(`LCBF_DUTY_FULL);

    // boost frequency from the active code
    wire [`LCBF_KHZ_W-1:0] khz_calc = code_to_khz(fsw_reg);

    lcbf_mult_rom u_mult (
        .code(max_i_reg),
        .mult(table_mult)
    );

    ////////////////////////////////////////////////////////////////////////
    // next-state for stored fields; host writes only count in host mode
    always_comb begin
        max_i_next = max_i_reg;
        trim_next = trim_reg;
        ext_next = ext_reg;
        fsw_next = fsw_reg;
        rsv_next = rsv_reg;
        state_next = state_reg;
        if (i2c_mode) begin
            if (max_i_wr) begin
                max_i_next = max_i_wdata;
            end
            if (trim_wr) begin
                trim_next = trim_wdata;
            end
            if (ext_sel_wr) begin
                ext_next = ext_sel_wdata;
            end
            // reserved codes are refused and flagged, old code kept
            if (fsw_wr && fsw_rsv_code) begin
                rsv_next = 1'b1;
            end else if (fsw_wr) begin
                fsw_next = fsw_wdata;
                rsv_next = 1'b0;
            end
        end
        case (state_reg)
            lcbf_pkg::LCBF_ST_WAIT: begin
                // strap keeps being tracked until the boost starts
                if (!i2c_mode) begin
                    fsw_next = strap_code;
                end
                if (switch_start) begin
                    state_next = lcbf_pkg::LCBF_ST_LOCKED;
                end
            end
            lcbf_pkg::LCBF_ST_LOCKED: begin
                // only reset leaves the lock, so late strap changes are ignored
                state_next = lcbf_pkg::LCBF_ST_LOCKED;
            end
            default: begin
                // unused code: go back to tracking the strap
                state_next = lcbf_pkg::LCBF_ST_WAIT;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration flops; sync reset loads documented defaults
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            max_i_reg <= `LCBF_MAX_I_RESET;
            trim_reg <= '0;
            ext_reg <= 1'b0;
            fsw_reg <= FSW_RESET;
            rsv_reg <= 1'b0;
            state_reg <= lcbf_pkg::LCBF_ST_WAIT;
        end else begin
            max_i_reg <= max_i_next;
            trim_reg <= trim_next;
            ext_reg <= ext_next;
            fsw_reg <= fsw_next;
            rsv_reg <= rsv_next;
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs, one cycle behind the stored fields
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            max_i_out_reg <= `LCBF_MAX_I_RESET;
            ma_reg <= '0;
            pct_reg <= '0;
            ua_reg <= '0;
            mult_reg <= `LCBF_MULT_BASE;
            duty_reg <= '0;
            khz_reg <= '0;
        end else begin
            max_i_out_reg <= max_i_reg;
            ma_reg <= coarse_ma;
            pct_reg <= pct_calc;
            ua_reg <= ua_scaled[`LCBF_UA_W-1:0];
            mult_reg <= mult_sel;
            duty_reg <= duty_sel;
            // frequency lags the code by one edge; the sinks never see a gap
            khz_reg <= khz_calc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // current side outputs, straight from flops
    assign max_i_code = max_i_out_reg;
    assign full_scale_ma = ma_reg;
    assign current_fine_trim = trim_reg;
    assign trim_pct_x100 = pct_reg;
    assign sink_current_ua = ua_reg;
    assign external_resistor_select = ext_reg;
    assign resistor_current_multiplier = mult_reg;
    assign current_duty_scale = duty_reg;

    // frequency side outputs, straight from flops
    assign fsw_code = fsw_reg;
    assign fsw_khz = khz_reg;
    assign fsw_locked = locked;
    assign fsw_reserved_err = rsv_reg;
endmodule

// ---- rtl/lcbf_mult_rom.sv ----
/*
 * Multiplier table for resistor current mode, in hundredths.
 * Assumes a 5-bit code from the current configuration.
 */
`timescale 1ns/1ns
`include "lcbf_regs.svh"
module lcbf_mult_rom (
    input wire logic [`LCBF_CODE_W-1:0] code,
    output logic [`LCBF_MULT_W-1:0] mult
);
    ////////////////////////////////////////////////////////////////////////
    // printed values are not exact thirds, so a table beats arithmetic
    always_comb begin
        case (code)
            5'h00: mult = 18'h09C40; 5'h01: mult = 18'h0A945;
            5'h02: mult = 18'h0B64B; 5'h03: mult = 18'h0C350;
            5'h04: mult = 18'h0D055; 5'h05: mult = 18'h0DD5B;
            5'h06: mult = 18'h0EA60; 5'h07: mult = 18'h0F765;
            5'h08: mult = 18'h1046A; 5'h09: mult = 18'h11170;
            5'h0A: mult = 18'h11E75; 5'h0B: mult = 18'h12B7A;
            5'h0C: mult = 18'h13880; 5'h0D: mult = 18'h14585;
            5'h0E: mult = 18'h1528A; 5'h0F: mult = 18'h15F90;
            5'h10: mult = 18'h16C95; 5'h11: mult = 18'h1799A;
            5'h12: mult = 18'h1869F; 5'h13: mult = 18'h193A5;
            5'h14: mult = 18'h1A0AA; 5'h15: mult = 18'h1ADAF;
            5'h16: mult = 18'h1BAB5; 5'h17: mult = 18'h1C7BA;
            5'h18: mult = 18'h1D4BF; 5'h19: mult = 18'h1E1C5;
            5'h1A: mult = 18'h1EECA; 5'h1B: mult = 18'h1FBCF;
            5'h1C: mult = 18'h208D4; 5'h1D: mult = 18'h215DA;
            5'h1E: mult = 18'h222DF; 5'h1F: mult = 18'h22FE4;
            default: mult = `LCBF_MULT_BASE;
        endcase
    end
endmodule

// ---- rtl/lcbf_pkg.sv ----
/*
 * Types for the configuration decode block.
 * Assumes lcbf_regs.svh is on the include path.
 */
`include "lcbf_regs.svh"
package lcbf_pkg;
    // strap level seen on the data pin when no host is present
    typedef enum logic [1:0] {
        LCBF_SDA_LOW = 2'h0,
        LCBF_SDA_OPEN = 2'h1,
        LCBF_SDA_HIGH = 2'h2
    } lcbf_sda_t;
    // startup latch state
    typedef enum logic [0:0] {
        LCBF_ST_WAIT = 1'h0,
        LCBF_ST_LOCKED = 1'h1
    } lcbf_state_t;
endpackage

// ---- rtl/lcbf_regs.svh ----
/*
 * Constants for the LED current and boost frequency configuration decode:
 * code widths, reset defaults, strap codes and table scaling.
 * Assumes inclusion by bare name from the package and the RTL modules.
 */
// How it works
// - Current code resets to the 43 mA value
// - Fine trim adds 0.51 percent per step
// - External mode current uses table multiplier
// - PWM mode scales current by duty cycle in external mode only
// - Strap mode multiplier fixed at 999.99 default
// - Frequency code sets boost switching frequency
// - Strap mode tracks SDA level until switching starts, keeping the last one
// - Strap frequency stays latched once switching has begun; host writes still apply
// - SDA high and open pick fixed codes
// - SDA grounded uses stored frequency default
`ifndef LCBF_REGS_SVH
`define LCBF_REGS_SVH

`define LCBF_CODE_W 5
`define LCBF_TRIM_W 4
`define LCBF_DUTY_W 8
`define LCBF_MA_W 6
`define LCBF_KHZ_W 14
// multiplier held in hundredths, 1433.32 fits 18 bits
`define LCBF_MULT_W 18
// fine trim in hundredths of a percent, 7.66% max
`define LCBF_TRIM_PCT_W 10
// current in microamps after trim and duty scaling
`define LCBF_UA_W 16

`define LCBF_MAX_I_RESET 5'h1F
`define LCBF_FSW_RESET 5'h13
`define LCBF_FSW_SDA_HIGH 5'h08
`define LCBF_FSW_SDA_OPEN 5'h0D
`define LCBF_FSW_MIN_CODE 5'h02
`define LCBF_BASE_MA 6'h0C
`define LCBF_BASE_KHZ 14'h2800
// 7.66% over 15 steps, total in hundredths of a percent
`define LCBF_TRIM_TOP 10'h2FE
`define LCBF_TRIM_STEPS 4'hF
`define LCBF_MULT_NONI2C 18'h1869F
`define LCBF_MULT_LAST 18'h22FE4
`define LCBF_MULT_BASE 18'h9C40
// current scaling: microamps per mA, percent hundredths, full duty
`define LCBF_UA_PER_MA 32'h3E8
`define LCBF_PCT_SCALE 32'h2710
`define LCBF_DUTY_FULL 8'hFF

`endif

// ---- tb/lcbf_config_decode_properties.sv ----
/* Assertions on the config decode ports.
   Assumes it is bound onto lcbf_config_decode with its parameters. */
`timescale 1ns/1ns
`include "lcbf_regs.svh"
module lcbf_checker #(
    parameter logic [`LCBF_CODE_W-1:0] FSW_RESET = `LCBF_FSW_RESET,
    parameter logic [`LCBF_MULT_W-1:0] MULT_NONI2C = `LCBF_MULT_NONI2C
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic i2c_mode,
    input wire logic fsw_wr,
    input wire logic [`LCBF_CODE_W-1:0] fsw_wdata,
    input wire lcbf_pkg::lcbf_sda_t sda_strap,
    input wire logic switch_start,
    input wire logic [`LCBF_CODE_W-1:0] max_i_code,
    input wire logic [`LCBF_MA_W-1:0] full_scale_ma,
    input wire logic [`LCBF_TRIM_W-1:0] current_fine_trim,
    input wire logic [`LCBF_TRIM_PCT_W-1:0] trim_pct_x100,
    input wire logic [`LCBF_MULT_W-1:0] resistor_current_multiplier,
    input wire logic [`LCBF_CODE_W-1:0] fsw_code,
    input wire logic [`LCBF_KHZ_W-1:0] fsw_khz,
    input wire logic fsw_locked,
    input wire logic fsw_reserved_err
);
    logic [1:0] up_reg;
    logic settled;
    logic [4:0] strap_exp;
    logic [13:0] khz_exp;
    logic [13:0] khz_div;
    logic [9:0] trim_exp;
    ////////////////////////////////////////////////////////////////////////
    // derived outputs are not checked until three edges after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            up_reg <= 2'h0;
        end else if (up_reg != 2'h3) begin
            up_reg <= up_reg + 2'h1;
        end
    end
    // expected values worked out independently of the design tables
    assign settled = (up_reg == 2'h3);
    assign strap_exp = (sda_strap == lcbf_pkg::LCBF_SDA_HIGH) ? 5'h08 :
        (sda_strap == lcbf_pkg::LCBF_SDA_OPEN) ? 5'h0D : FSW_RESET;
    // table frequencies are the base over code plus one, rounded to nearest
    assign khz_div = {9'h0, fsw_code} + 14'h1;
    assign khz_exp = (14'h2800 + (khz_div >> 1)) / khz_div;
    assign trim_exp = 10'((14'(current_fine_trim) * 14'h2FE) / 14'hF);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    property p_ma;
        settled && $stable(max_i_code) |-> full_scale_ma == 6'(max_i_code) + 6'h0C;
    endproperty
    a_ma: assert property (p_ma) else $error("current code to mA wrong");
    property p_trim;
        settled && $stable(current_fine_trim) |-> trim_pct_x100 == trim_exp;
    endproperty
    a_trim: assert property (p_trim) else $error("trim percent wrong");
    property p_mult;
        settled && !i2c_mode && !$past(i2c_mode) && !$past(i2c_mode, 2)
            |-> resistor_current_multiplier == MULT_NONI2C;
    endproperty
    a_mult: assert property (p_mult) else $error("strap multiplier wrong");
    property p_wr;
        i2c_mode && fsw_wr && fsw_wdata >= 5'h02 |=> fsw_code == $past(fsw_wdata);
    endproperty
    a_wr: assert property (p_wr) else $error("frequency write lost");
    property p_strap;
        !i2c_mode && !fsw_locked && !switch_start |=> fsw_code == $past(strap_exp);
    endproperty
    a_strap: assert property (p_strap) else $error("strap code wrong");
    property p_lock;
        switch_start |=> fsw_locked [*2];
    endproperty
    a_lock: assert property (p_lock) else $error("lock not held");
    property p_frozen;
        fsw_locked && !i2c_mode |=> $stable(fsw_code);
    endproperty
    a_frozen: assert property (p_frozen) else $error("code moved after lock");
    property p_khz;
        settled && $stable(fsw_code) && fsw_code >= 5'h02 |-> fsw_khz == khz_exp;
    endproperty
    a_khz: assert property (p_khz) else $error("frequency kHz wrong");
    property p_err;
        i2c_mode && fsw_wr && fsw_wdata < 5'h02 |=> fsw_reserved_err && $stable(fsw_code);
    endproperty
    a_err: assert property (p_err) else $error("reserved code taken");
endmodule

bind lcbf_config_decode lcbf_checker #(.FSW_RESET(FSW_RESET), .MULT_NONI2C(MULT_NONI2C)) u_chk (
    .clk, .sys_rst, .i2c_mode, .fsw_wr, .fsw_wdata, .sda_strap, .switch_start, .max_i_code,
    .full_scale_ma, .current_fine_trim, .trim_pct_x100, .resistor_current_multiplier,
    .fsw_code, .fsw_khz, .fsw_locked, .fsw_reserved_err
);

// ---- tb/lcbf_config_decode_tb.sv ----
/* Self-checking bench for the config decode block.
   Assumes the strap model and checker are compiled alongside. */
`timescale 1ns/1ns
module lcbf_config_decode_tb;
    logic clk, sys_rst, i2c_mode, max_i_wr, trim_wr, fsw_wr, ext_sel_wr, ext_sel_wdata;
    logic pwm_mode, switch_start, external_resistor_select, fsw_locked, fsw_reserved_err;
    logic [4:0] max_i_wdata, fsw_wdata, max_i_code, fsw_code;
    logic [3:0] trim_wdata, current_fine_trim;
    logic [7:0] pwm_duty, current_duty_scale;
    logic [1:0] lvl;
    logic [5:0] full_scale_ma;
    logic [9:0] trim_pct_x100;
    logic [15:0] sink_current_ua;
    logic [17:0] resistor_current_multiplier;
    logic [13:0] fsw_khz;
    lcbf_pkg::lcbf_sda_t sda_strap;
    int err_count = 0;
    int checks_done = 0;
    ////////////////////////////////////////////////////////////////////////
    lcbf_strap_model u_strap (.clk, .level(lvl), .sda_strap);
    lcbf_config_decode DUT (.clk, .sys_rst, .i2c_mode, .max_i_wr, .max_i_wdata, .trim_wr,
        .trim_wdata, .fsw_wr, .fsw_wdata, .ext_sel_wr, .ext_sel_wdata, .pwm_mode, .pwm_duty,
        .sda_strap, .switch_start, .max_i_code, .full_scale_ma, .current_fine_trim,
        .trim_pct_x100, .sink_current_ua, .external_resistor_select,
        .resistor_current_multiplier, .current_duty_scale, .fsw_code, .fsw_khz, .fsw_locked,
        .fsw_reserved_err);
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // f one-hot: 8 current, 4 trim, 2 frequency, 1 resistor select
    task automatic wr(input logic [3:0] f, input logic [4:0] d);
        {max_i_wr, trim_wr, fsw_wr, ext_sel_wr} = f;
        {max_i_wdata, fsw_wdata, trim_wdata, ext_sel_wdata} = {d, d, d[3:0], d[0]};
        cyc(1);
        {max_i_wr, trim_wr, fsw_wr, ext_sel_wr} = 4'h0;
        cyc(2);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_current();
        logic [4:0] c [3] = '{5'h00, 5'h12, 5'h1F};
        logic [17:0] m [3] = '{18'h9C40, 18'h1869F, 18'h22FE4};
        chk(max_i_code, 5'h1F);
        chk(full_scale_ma, 6'h2B);
        wr(4'h1, 5'h01);
        chk(external_resistor_select, 1'b1);
        for (int i = 0; i < 3; i++) begin
            wr(4'h8, c[i]);
            chk(full_scale_ma, 6'h0C + 6'(c[i]));
            chk(resistor_current_multiplier, m[i]);
        end
    endtask
    task automatic t_trim_pwm();
        wr(4'h4, 5'h0F);
        chk(trim_pct_x100, 10'h2FE);
        wr(4'h4, 5'h01);
        chk(trim_pct_x100, 10'h033);
        pwm_mode = 1'b1;
        pwm_duty = 8'h80;
        cyc(3);
        chk(current_duty_scale, 8'h80);
        chk(sink_current_ua, 16'h54BE);
        wr(4'h1, 5'h00);
        chk(current_duty_scale, 8'hFF);
        chk(external_resistor_select, 1'b0);
        chk(sink_current_ua, 16'hA8D3);
    endtask
    task automatic t_fsw();
        logic [4:0] c [4] = '{5'h02, 5'h1F, 5'h05, 5'h07};
        logic [13:0] k [4] = '{14'hD55, 14'h140, 14'h6AB, 14'h500};
        chk(fsw_khz, 14'h200);
        for (int i = 0; i < 4; i++) begin
            wr(4'h2, c[i]);
            chk(fsw_khz, k[i]);
        end
        wr(4'h2, 5'h01);
        chk(fsw_reserved_err, 1'b1);
        chk(fsw_code, 5'h07);
    endtask
    // lock is sticky until reset, so this runs last
    task automatic t_strap();
        logic [1:0] l [3] = '{2'h2, 2'h1, 2'h0};
        logic [4:0] c [3] = '{5'h08, 5'h0D, 5'h13};
        i2c_mode = 1'b0;
        for (int i = 0; i < 3; i++) begin
            lvl = l[i];
            cyc(3);
            chk(fsw_code, c[i]);
        end
        chk(resistor_current_multiplier, 18'h1869F);
        wr(4'h8, 5'h00);
        chk(max_i_code, 5'h1F);
        lvl = 2'h2;
        cyc(3);
        switch_start = 1'b1;
        cyc(1);
        switch_start = 1'b0;
        lvl = 2'h0;
        cyc(3);
        chk(fsw_locked, 1'b1);
        chk(fsw_code, 5'h08);
        chk(fsw_khz, 14'h472);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {sys_rst, i2c_mode, max_i_wr, trim_wr, fsw_wr, ext_sel_wr} = 6'h30;
        {ext_sel_wdata, pwm_mode, switch_start} = 3'h0;
        {max_i_wdata, fsw_wdata, trim_wdata, pwm_duty, lvl} = 24'h0;
        cyc(4);
        sys_rst = 1'b0;
        cyc(2);
        t_current();
        t_trim_pwm();
        t_fsw();
        t_strap();
        final_report();
    end
    // watchdog, far beyond the 64 cycles the tests need
    initial begin
        #200000;
        err_count++;
        final_report();
    end
endmodule

// ---- tb/lcbf_strap_model.sv ----
/* Strap pin model standing in for the board at the data pin.
   Assumes the bench picks the level; it reaches the decode one flop later. */
`timescale 1ns/1ns
module lcbf_strap_model (
    input wire logic clk,
    input wire logic [1:0] level,
    output lcbf_pkg::lcbf_sda_t sda_strap
);
    // pad synchroniser, so a level change lands a cycle late as on silicon
    always_ff @(posedge clk) begin
        sda_strap <= lcbf_pkg::lcbf_sda_t'(level);
    end
endmodule
